//--- design/gcb_config_bank.sv
/*
 * gcb_config_bank: gauge configuration register bank with the switch,
 * interrupt, flash-write and sleep gating that the options steer.
 * assumes inputs synchronous to ref_clk; read data one cycle after strobe.
 */
// The implementer's own choice: strobed register access.
//
// Summary of operation
// - option b bit 6 enables tab detach check
// - option b bit 4 enables internal short check
// - option b bit 2 selects long relaxation
// - option b bit 1 enables discharge depth weighting
// - options b, c reset to a7, b9
// - option c bit 7 enables fast capacity update
// - option c bit 4 enables smoothing
// - option c bit 5 smooths during relaxation when bit 4 is set
// - option c bit 0 passes level interrupts only
// - option d bit 7 overtemp opens switches
// - option d bit 6 full charge opens charge
// - option d bit 5 inhibit opens charge
// - option d bit 4 suspend opens charge
// - option d bit 3 equalises instantly in relax
// - option d bits 0,1 max current; reset 83
// - overcurrent bit 5 picks 73/148 mV short
// - overcurrent bits 4:2 discharge 14..83 mV
// - overcurrent bits 1:0 charge 6..28 mV
// - overvoltage bits 2:0 4.275..4.450 V; reset 07
// - lifetime writes spaced by configured interval
// - flash writes blocked below limit unless charger
// - sleep when current inside band and enabled
// - sleep option bit gates sleep entry
module gcb_config_bank (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// gauge conditions
	input wire logic [15:0] battery_mv,
	input wire logic charger_present,
	input wire logic signed [15:0] mean_current,
	input wire logic sleep_conditions_ok,
	input wire logic lt_write_req,
	input wire logic flash_write_req,
	input wire gcb_pkg::gcb_flags_s flags,
	// interrupt sources
	input wire logic level_irq_src,
	input wire logic other_irq_src,
	// results
	output gcb_pkg::gcb_feature_s features,
	output gcb_pkg::gcb_thresh_s thresholds,
	output logic interrupt_pin,
	output logic charge_switch,
	output logic discharge_switch,
	output logic flash_write_grant,
	output logic lt_write_grant,
	output logic sleep_enter
);

	////////////////////////////////////////////////////////////////////
	// storage

	logic [15:0] flash_write_min_voltage;
	logic [15:0] sleep_current_band;
	logic [15:0] lifetime_write_interval;
	logic [7:0] pack_options_a;
	logic [7:0] pack_options_b;
	logic [7:0] pack_options_c;
	logic [7:0] pack_options_d;
	logic [7:0] protector_overcurrent_cfg;
	logic [7:0] protector_overvoltage_cfg;
	logic lt_wait;
	logic [26:0] lt_sec_cnt;
	logic [15:0] lt_secs;
	logic lt_done;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		hit = (a == r);
	endfunction

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			flash_write_min_voltage <= gcb_pkg::RST_FLASH_MIN_V;
			sleep_current_band <= gcb_pkg::RST_SLEEP_BAND;
			lifetime_write_interval <= gcb_pkg::RST_LT_INTERVAL;
		end else if (reg_wr) begin
			if (hit(reg_addr, gcb_pkg::ADDR_FLASH_MIN_V))
				flash_write_min_voltage <= reg_wdata;
			if (hit(reg_addr, gcb_pkg::ADDR_SLEEP_BAND))
				sleep_current_band <= reg_wdata;
			if (hit(reg_addr, gcb_pkg::ADDR_LT_INTERVAL))
				lifetime_write_interval <= reg_wdata;
		end
	end

	// reserved bits are masked off on write so they always read zero
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pack_options_a <= gcb_pkg::RST_OPT_A;
			pack_options_b <= gcb_pkg::RST_OPT_B;
			pack_options_c <= gcb_pkg::RST_OPT_C;
			pack_options_d <= gcb_pkg::RST_OPT_D;
			protector_overcurrent_cfg <= gcb_pkg::RST_PROT_OC;
			protector_overvoltage_cfg <= gcb_pkg::RST_PROT_OV;
		end else if (reg_wr) begin
			if (hit(reg_addr, gcb_pkg::ADDR_OPT_A))
				pack_options_a <= reg_wdata[7:0];
			if (hit(reg_addr, gcb_pkg::ADDR_OPT_B))
				pack_options_b <= reg_wdata[7:0] & gcb_pkg::MASK_OPT_B;
			if (hit(reg_addr, gcb_pkg::ADDR_OPT_C))
				pack_options_c <= reg_wdata[7:0] & gcb_pkg::MASK_OPT_C;
			if (hit(reg_addr, gcb_pkg::ADDR_OPT_D))
				pack_options_d <= reg_wdata[7:0] & gcb_pkg::MASK_OPT_D;
			if (hit(reg_addr, gcb_pkg::ADDR_PROT_OC))
				protector_overcurrent_cfg <=
					reg_wdata[7:0] & gcb_pkg::MASK_PROT_OC;
			if (hit(reg_addr, gcb_pkg::ADDR_PROT_OV))
				protector_overvoltage_cfg <=
					reg_wdata[7:0] & gcb_pkg::MASK_PROT_OV;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read port

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				gcb_pkg::ADDR_FLASH_MIN_V: reg_rdata <= flash_write_min_voltage;
				gcb_pkg::ADDR_SLEEP_BAND: reg_rdata <= sleep_current_band;
				gcb_pkg::ADDR_OPT_B: reg_rdata <= {8'h00, pack_options_b};
				gcb_pkg::ADDR_OPT_C: reg_rdata <= {8'h00, pack_options_c};
				gcb_pkg::ADDR_LT_INTERVAL: reg_rdata <= lifetime_write_interval;
				gcb_pkg::ADDR_OPT_D: reg_rdata <= {8'h00, pack_options_d};
				gcb_pkg::ADDR_PROT_OC:
					reg_rdata <= {8'h00, protector_overcurrent_cfg};
				gcb_pkg::ADDR_PROT_OV:
					reg_rdata <= {8'h00, protector_overvoltage_cfg};
				gcb_pkg::ADDR_OPT_A: reg_rdata <= {8'h00, pack_options_a};
				gcb_pkg::ADDR_STATUS:
					reg_rdata <= {10'h000, sleep_enter, lt_wait,
						flash_write_grant, interrupt_pin,
						discharge_switch, charge_switch};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// feature enables

	always_comb begin
		features.tab_detach_check_en =
			pack_options_b[gcb_pkg::OPT_B_TAB];
		features.internal_short_check_en =
			pack_options_b[gcb_pkg::OPT_B_ISD];
		features.long_relax_en = pack_options_b[gcb_pkg::OPT_B_LRELAX];
		features.discharge_depth_weight_en =
			pack_options_b[gcb_pkg::OPT_B_DODW];
		features.fast_capacity_update_en =
			pack_options_c[gcb_pkg::OPT_C_FASTQ];
		features.charge_smoothing_en =
			pack_options_c[gcb_pkg::OPT_C_SMOOTH];
		// relaxation smoothing rides on the main smoothing enable
		features.relax_smoothing_en = pack_options_c[gcb_pkg::OPT_C_SMOOTH]
			& pack_options_c[gcb_pkg::OPT_C_RLXSM];
		features.relax_instant_equalise_en =
			pack_options_d[gcb_pkg::OPT_D_SYNC];
		features.max_discharge_report_en =
			pack_options_d[gcb_pkg::OPT_D_IMAX];
		features.max_discharge_reserve_en =
			pack_options_d[gcb_pkg::OPT_D_RESV];
	end

	////////////////////////////////////////////////////////////////////
	// protector thresholds

	always_comb begin
		thresholds.short_circuit_mv =
			protector_overcurrent_cfg[gcb_pkg::OC_SCD] ?
			gcb_pkg::SCD_MV_HI : gcb_pkg::SCD_MV_LO;
		unique case (protector_overcurrent_cfg[4:2])
			3'b000: thresholds.discharge_oc_mv = 16'h000e;
			3'b001: thresholds.discharge_oc_mv = 16'h0018;
			3'b010: thresholds.discharge_oc_mv = 16'h0022;
			3'b011: thresholds.discharge_oc_mv = 16'h002c;
			3'b100: thresholds.discharge_oc_mv = 16'h0035;
			3'b101: thresholds.discharge_oc_mv = 16'h003f;
			3'b110: thresholds.discharge_oc_mv = 16'h0049;
			3'b111: thresholds.discharge_oc_mv = 16'h0053;
		endcase
		unique case (protector_overcurrent_cfg[1:0])
			2'b00: thresholds.charge_oc_mv = 16'h0006;
			2'b01: thresholds.charge_oc_mv = 16'h000d;
			2'b10: thresholds.charge_oc_mv = 16'h0012;
			2'b11: thresholds.charge_oc_mv = 16'h001c;
		endcase
		// 4275 mV plus 25 mV per code step
		thresholds.cell_ov_mv = 16'h10b3
			+ 16'(protector_overvoltage_cfg[2:0]) * 16'h0019;
	end

	////////////////////////////////////////////////////////////////////
	// switches and interrupt pin

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			charge_switch <= 1'b0;
			discharge_switch <= 1'b0;
		end else begin
			charge_switch <= ~(
				(pack_options_d[gcb_pkg::OPT_D_OT]
					& flags.charge_overtemp_fault)
				| (pack_options_d[gcb_pkg::OPT_D_FC]
					& flags.full_charge_flag)
				| (pack_options_d[gcb_pkg::OPT_D_INH]
					& flags.charge_inhibit_flag)
				| (pack_options_d[gcb_pkg::OPT_D_SUS]
					& flags.charge_suspend_flag));
			discharge_switch <= ~(pack_options_d[gcb_pkg::OPT_D_OT]
				& flags.discharge_overtemp_fault);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			interrupt_pin <= 1'b0;
		else if (pack_options_c[gcb_pkg::OPT_C_LEVEL])
			interrupt_pin <= level_irq_src;
		else
			interrupt_pin <= level_irq_src | other_irq_src;
	end

	////////////////////////////////////////////////////////////////////
	// flash write gating and lifetime spacing

	logic volt_ok;
	assign volt_ok = charger_present
		| (battery_mv >= flash_write_min_voltage);
	assign flash_write_grant = flash_write_req & volt_ok;
	assign lt_done = (lt_secs >= lifetime_write_interval);
	assign lt_write_grant = lt_write_req & volt_ok & ~lt_wait;

	// one-second tick and elapsed-seconds count since the last lifetime write
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			lt_wait <= 1'b0;
			lt_sec_cnt <= '0;
			lt_secs <= 16'h0000;
		end else if (lt_write_grant) begin
			lt_wait <= (lifetime_write_interval != 16'h0000);
			lt_sec_cnt <= '0;
			lt_secs <= 16'h0000;
		end else if (lt_wait) begin
			if (lt_done) begin
				lt_wait <= 1'b0;
			end else if (lt_sec_cnt == 27'(gcb_pkg::LT_UNIT_CYC - 1)) begin
				lt_sec_cnt <= '0;
				lt_secs <= lt_secs + 16'h0001;
			end else begin
				lt_sec_cnt <= lt_sec_cnt + 27'h000_0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// sleep entry

	logic [15:0] cur_mag;
	assign cur_mag = mean_current[15] ? 16'(-mean_current)
		: 16'(mean_current);

	always_ff @(posedge ref_clk) begin
		if (sys_rst)
			sleep_enter <= 1'b0;
		else
			sleep_enter <= pack_options_a[gcb_pkg::OPT_A_SLEEP]
				& sleep_conditions_ok
				& (cur_mag < sleep_current_band);
	end

endmodule // gcb_config_bank

//--- design/gcb_pkg.sv
/*
 * gcb_pkg: register map, field positions, reset values and decode
 * tables for the gauge configuration bank.
 * assumes a single 125 MHz clock and a plain strobe register port.
 */
package gcb_pkg;

	// register indices on the plain port (4-bit index, 16-bit data)
	localparam logic [3:0] ADDR_FLASH_MIN_V = 4'h0;
	localparam logic [3:0] ADDR_SLEEP_BAND = 4'h1;
	localparam logic [3:0] ADDR_OPT_B = 4'h2;
	localparam logic [3:0] ADDR_OPT_C = 4'h3;
	localparam logic [3:0] ADDR_LT_INTERVAL = 4'h4;
	localparam logic [3:0] ADDR_OPT_D = 4'h5;
	localparam logic [3:0] ADDR_PROT_OC = 4'h6;
	localparam logic [3:0] ADDR_PROT_OV = 4'h7;
	localparam logic [3:0] ADDR_OPT_A = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'h9;

	// reset values
	localparam logic [15:0] RST_FLASH_MIN_V = 16'h0af0;
	localparam logic [15:0] RST_SLEEP_BAND = 16'h000f;
	localparam logic [15:0] RST_LT_INTERVAL = 16'h003c;
	localparam logic [7:0] RST_OPT_A = 8'h7f;
	localparam logic [7:0] RST_OPT_B = 8'ha7;
	localparam logic [7:0] RST_OPT_C = 8'hb9;
	localparam logic [7:0] RST_OPT_D = 8'h83;
	localparam logic [7:0] RST_PROT_OC = 8'h0a;
	localparam logic [7:0] RST_PROT_OV = 8'h07;

	// writable-bit masks: reserved bits are held at zero
	localparam logic [7:0] MASK_OPT_B = 8'hf7;
	localparam logic [7:0] MASK_OPT_C = 8'hf9;
	localparam logic [7:0] MASK_OPT_D = 8'hfb;
	localparam logic [7:0] MASK_PROT_OC = 8'h3f;
	localparam logic [7:0] MASK_PROT_OV = 8'h07;

	// field positions
	localparam int OPT_A_SLEEP = 5;
	localparam int OPT_B_TAB = 6;
	localparam int OPT_B_ISD = 4;
	localparam int OPT_B_LRELAX = 2;
	localparam int OPT_B_DODW = 1;
	localparam int OPT_C_FASTQ = 7;
	localparam int OPT_C_RLXSM = 5;
	localparam int OPT_C_SMOOTH = 4;
	localparam int OPT_C_LEVEL = 0;
	localparam int OPT_D_OT = 7;
	localparam int OPT_D_FC = 6;
	localparam int OPT_D_INH = 5;
	localparam int OPT_D_SUS = 4;
	localparam int OPT_D_SYNC = 3;
	localparam int OPT_D_RESV = 1;
	localparam int OPT_D_IMAX = 0;
	localparam int OC_SCD = 5;

	// lifetime interval unit: one second at 125 MHz
	localparam int CLK_HZ = 125_000_000;
	localparam int LT_UNIT_S = 1;
	localparam int LT_UNIT_CYC = CLK_HZ * LT_UNIT_S;

	// thresholds in mV (cell overvoltage in mV as well)
	localparam logic [15:0] SCD_MV_LO = 16'h0049;
	localparam logic [15:0] SCD_MV_HI = 16'h0094;

	typedef struct packed {
		logic tab_detach_check_en;
		logic internal_short_check_en;
		logic long_relax_en;
		logic discharge_depth_weight_en;
		logic fast_capacity_update_en;
		logic charge_smoothing_en;
		logic relax_smoothing_en;
		logic relax_instant_equalise_en;
		logic max_discharge_report_en;
		logic max_discharge_reserve_en;
	} gcb_feature_s;

	typedef struct packed {
		logic [15:0] short_circuit_mv;
		logic [15:0] discharge_oc_mv;
		logic [15:0] charge_oc_mv;
		logic [15:0] cell_ov_mv;
	} gcb_thresh_s;

	typedef struct packed {
		logic charge_overtemp_fault;
		logic discharge_overtemp_fault;
		logic full_charge_flag;
		logic charge_inhibit_flag;
		logic charge_suspend_flag;
	} gcb_flags_s;

endpackage

//--- dv/gcb_config_bank_assertions.sv
/*
 * gcb_config_bank_checker: port-level checks of the config bank.
 * assumes binding into gcb_config_bank; one clock domain.
 */
module gcb_config_bank_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// register port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// conditions
	input wire logic charger_present,
	input wire logic flash_write_req,
	input wire logic lt_write_req,
	input wire logic sleep_conditions_ok,
	input wire gcb_pkg::gcb_flags_s flags,
	input wire logic level_irq_src,
	input wire logic other_irq_src,
	// results
	input wire gcb_pkg::gcb_feature_s features,
	input wire gcb_pkg::gcb_thresh_s thresholds,
	input wire logic interrupt_pin,
	input wire logic charge_switch,
	input wire logic discharge_switch,
	input wire logic flash_write_grant,
	input wire logic lt_write_grant,
	input wire logic sleep_enter
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_was_running;
		!$past(sys_rst);
	endsequence
	sequence s_no_flags;
		$past(flags) == 5'h00;
	endsequence

	property p_rst_val;
		disable iff (1'b0) sys_rst |=> features == 10'h0fb &&
			thresholds == 64'h0049_0022_0012_1162;
	endproperty
	property p_rd_idle;
		!$past(reg_rd) |-> reg_rdata == 16'h0000;
	endproperty
	property p_th_hold;
		!$stable(thresholds) |-> $past(reg_wr) || $past(sys_rst);
	endproperty
	property p_irq_cause;
		interrupt_pin |-> $past(level_irq_src) || $past(other_irq_src);
	endproperty
	property p_irq_level;
		s_was_running ##0 $past(level_irq_src) |-> interrupt_pin;
	endproperty
	property p_dsg_on;
		s_was_running ##0 !$past(flags.discharge_overtemp_fault)
			|-> discharge_switch;
	endproperty
	property p_chg_on;
		s_was_running ##0 s_no_flags |-> charge_switch;
	endproperty
	property p_flash_chg;
		flash_write_req && charger_present |-> flash_write_grant;
	endproperty
	property p_lt_gate;
		lt_write_grant |-> lt_write_req &&
			!(flash_write_req && !flash_write_grant);
	endproperty
	property p_sleep;
		sleep_enter |-> $past(sleep_conditions_ok);
	endproperty

	a_rst_val: assert property (p_rst_val)
		else $error("reset option or threshold value wrong");
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data outside read cycle");
	a_th_hold: assert property (p_th_hold)
		else $error("thresholds moved without a write");
	a_irq_cause: assert property (p_irq_cause)
		else $error("interrupt pin without a source");
	a_irq_level: assert property (p_irq_level)
		else $error("level interrupt not signalled");
	a_dsg_on: assert property (p_dsg_on)
		else $error("discharge switch off without fault");
	a_chg_on: assert property (p_chg_on)
		else $error("charge switch off without cause");
	a_flash_chg: assert property (p_flash_chg)
		else $error("flash write blocked with charger");
	a_lt_gate: assert property (p_lt_gate)
		else $error("lifetime write granted wrongly");
	a_sleep: assert property (p_sleep)
		else $error("sleep entered without conditions");
endmodule // gcb_config_bank_checker

bind gcb_config_bank gcb_config_bank_checker u_chk (.*);

//--- dv/gcb_host_model.sv
/*
 * gcb_host_model: host side of the plain register port.
 * assumes one ref_clk for both sides; read data stand one cycle later.
 */
module gcb_host_model (
	// clock
	input wire logic ref_clk,
	// register port
	output logic [3:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [15:0] reg_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// reserved bits go out as zero while the write strobe is high
	function automatic logic [15:0] clean(input logic [3:0] a,
		input logic [15:0] d);
		case (a)
			gcb_pkg::ADDR_OPT_B: return {8'h00, d[7:0] & 8'hf7};
			gcb_pkg::ADDR_OPT_C: return {8'h00, d[7:0] & 8'hf9};
			gcb_pkg::ADDR_OPT_D: return {8'h00, d[7:0] & 8'hfb};
			gcb_pkg::ADDR_PROT_OC: return {8'h00, d[7:0] & 8'h3f};
			gcb_pkg::ADDR_PROT_OV: return {8'h00, d[7:0] & 8'h07};
			default: return d;
		endcase
	endfunction

	// released write data flips so a stale value is never mistaken for data
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= clean(a, d);
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~clean(a, d);
	endtask

	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
endmodule // gcb_host_model

//--- dv/tb_gcb_config_bank.sv
/*
 * tb_gcb_config_bank: self-checking bench of the config bank.
 * assumes the host model drives the register port.
 */
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
	fail_count++; $display("wrong value at %0t: %h vs %h", $time, g, e); \
	end end
module tb_gcb_config_bank;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rv;
	logic reg_wr, reg_rd;
	logic [15:0] battery_mv = 16'h0000;
	logic signed [15:0] mean_current = 16'sh0000;
	logic charger_present = 1'b0, sleep_conditions_ok = 1'b0;
	logic lt_write_req = 1'b0, flash_write_req = 1'b0;
	logic level_irq_src = 1'b0, other_irq_src = 1'b0;
	gcb_pkg::gcb_flags_s flags = 5'h00, f;
	gcb_pkg::gcb_feature_s features;
	gcb_pkg::gcb_thresh_s thresholds;
	logic interrupt_pin, charge_switch, discharge_switch;
	logic flash_write_grant, lt_write_grant, sleep_enter;
	logic [7:0] b, c, d;
	logic [1:0] s;
	int fail_count = 0, num_checks = 0, cycles = 0;
	int oc_d [8] = '{14, 24, 34, 44, 53, 63, 73, 83};
	int oc_c [4] = '{6, 13, 18, 28};
	int cur [4] = '{14, -14, 15, -15};

	gcb_config_bank u_gcb_config_bank (.*);
	gcb_host_model u_host (.*);

	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////
	function automatic gcb_pkg::gcb_feature_s feat(input logic [7:0] b,
		input logic [7:0] c, input logic [7:0] d);
		return {b[6], b[4], b[2], b[1], c[7], c[4], c[5] & c[4], d[3],
			d[0], d[1]};
	endfunction
	function automatic logic [1:0] sw(input logic [7:0] d,
		input logic [4:0] f);
		return {~|(d[7:4] & {f[4], f[2], f[1], f[0]}), ~(d[7] & f[3])};
	endfunction
	task automatic rdc(input logic [3:0] a, input logic [15:0] e);
		u_host.rd(a, rv);
		`CHK(rv, e);
	endtask
	task automatic wait_out;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'hbcdacaf3));
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rdc(gcb_pkg::ADDR_FLASH_MIN_V, 16'h0af0);
		rdc(gcb_pkg::ADDR_SLEEP_BAND, 16'h000f);
		rdc(gcb_pkg::ADDR_OPT_B, 16'h00a7);
		rdc(gcb_pkg::ADDR_OPT_C, 16'h00b9);
		rdc(gcb_pkg::ADDR_LT_INTERVAL, 16'h003c);
		rdc(gcb_pkg::ADDR_OPT_D, 16'h0083);
		rdc(gcb_pkg::ADDR_PROT_OC, 16'h000a);
		rdc(gcb_pkg::ADDR_PROT_OV, 16'h0007);
		rdc(4'hf, 16'h0000);
		$display("test reset values done");
		for (int i = 0; i < 16; i++) begin
			b = 8'($urandom());
			c = 8'($urandom());
			d = 8'($urandom());
			u_host.wr(gcb_pkg::ADDR_OPT_B, {8'h00, b});
			u_host.wr(gcb_pkg::ADDR_OPT_C, {8'h00, c});
			u_host.wr(gcb_pkg::ADDR_OPT_D, {8'h00, d});
			#1 `CHK(features, feat(b, c, d));
		end
		$display("test feature bits done");
		for (int k = 0; k < 64; k++) begin
			u_host.wr(gcb_pkg::ADDR_PROT_OC, 16'(k));
			#1 `CHK(thresholds[63:16], {16'(k[5] ? 148 : 73),
				16'(oc_d[k[4:2]]), 16'(oc_c[k[1:0]])});
		end
		for (int k = 0; k < 8; k++) begin
			u_host.wr(gcb_pkg::ADDR_PROT_OV, 16'(k));
			#1 `CHK(thresholds[15:0], 16'(4275 + 25 * k));
		end
		$display("test thresholds done");
		for (int i = 0; i < 24; i++) begin
			d = (i < 8) ? 8'hf0 : 8'($urandom());
			f = (i < 5) ? 5'(1 << i) : 5'($urandom());
			u_host.wr(gcb_pkg::ADDR_OPT_D, {8'h00, d});
			@(posedge ref_clk);
			flags <= f;
			wait_out();
			`CHK({charge_switch, discharge_switch}, sw(d, f));
		end
		$display("test switches done");
		for (int k = 0; k < 8; k++) begin
			if (k[1:0] == 2'b00)
				u_host.wr(gcb_pkg::ADDR_OPT_C, {15'h0000, ~k[2]});
			@(posedge ref_clk);
			{level_irq_src, other_irq_src} <= k[1:0];
			wait_out();
			`CHK(interrupt_pin, k[1] | (k[0] & k[2]));
		end
		$display("test interrupt pin done");
		u_host.wr(gcb_pkg::ADDR_FLASH_MIN_V, 16'h0bb8);
		u_host.wr(gcb_pkg::ADDR_LT_INTERVAL, 16'h0000);
		for (int k = 0; k < 8; k++) begin
			@(posedge ref_clk);
			battery_mv <= 16'h0bb7 + 16'(k[0]);
			charger_present <= k[1];
			flash_write_req <= k[2];
			lt_write_req <= k[2];
			wait_out();
			`CHK({flash_write_grant, lt_write_grant},
				{2{k[2] & (k[0] | k[1])}});
		end
		u_host.wr(gcb_pkg::ADDR_LT_INTERVAL, 16'h0001);
		repeat (3) @(posedge ref_clk);
		#1 `CHK(lt_write_grant, 1'b0);
		`CHK(flash_write_grant, 1'b1);
		$display("test flash gating done");
		for (int k = 0; k < 12; k++) begin
			if (k == 8) u_host.wr(gcb_pkg::ADDR_OPT_A, 16'h005f);
			@(posedge ref_clk);
			mean_current <= 16'(cur[k % 4]);
			sleep_conditions_ok <= (k != 5);
			wait_out();
			`CHK(sleep_enter, 1'(k < 8 && k != 5 && k % 4 < 2));
		end
		// status: sleep off, lifetime wait on, grant on, pin on, switches
		s = sw(d, f);
		rdc(gcb_pkg::ADDR_STATUS, {10'h000, 4'b0111, s[0], s[1]});
		$display("test sleep entry done");
		complete_run();
	end
endmodule // tb_gcb_config_bank
